/* File: src/crac_pkg.sv */
// Package for the current route and conditioning amplifier register block.
// Assumes an 8-bit host port with 5 address bits on the device side.
package crac_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int CRAC_AW = 5;
	localparam int CRAC_DW = 8;
	localparam logic [4:0] CRAC_OFS_CUR_SEL = 5'h06;
	localparam logic [4:0] CRAC_OFS_AMP_CFG = 5'h07;
	localparam logic [7:0] CRAC_RST_CUR_SEL = 8'h00;
	localparam logic [7:0] CRAC_RST_AMP_CFG = 8'h00;
	localparam logic [7:0] CRAC_MASK_CUR_SEL = 8'h3F;
	localparam logic [7:0] CRAC_MASK_AMP_CFG = 8'h7F;
	localparam int CRAC_CH_NUM = 64;
	// Field positions in the amplifier register
	localparam int CRAC_BIT_SHUTOFF = 6;
	localparam int CRAC_POS_POLE2 = 4;
	localparam int CRAC_POS_POLE1 = 2;
	localparam int CRAC_POS_GAIN = 0;

	// ----------------------------------------
	// Encodings
	// ----------------------------------------
	typedef enum logic [1:0]
	{
		CRAC_POLE_400 = 2'h0,
		CRAC_POLE_2K = 2'h1,
		CRAC_POLE_10K = 2'h2,
		CRAC_POLE_RSV = 2'h3
	} crac_pole_t;
	typedef enum logic [1:0]
	{
		CRAC_GAIN_0P4 = 2'h0,
		CRAC_GAIN_2P0 = 2'h1,
		CRAC_GAIN_10 = 2'h2,
		CRAC_GAIN_10B = 2'h3
	} crac_gain_t;

	// Analog controls as one carrier
	typedef struct packed
	{
		logic amp_on;
		logic drive_low_z;
		logic [2:0] pole1_onehot;
		logic [2:0] pole2_onehot;
		logic [2:0] gain_onehot;
	} crac_amp_ctl_t;
endpackage

/* File: src/crac_decode.sv */
// One-hot channel decoder for the current source switch bank.
// Assumes the select value is registered upstream.
`timescale 1ns/1ps
module crac_decode
	import crac_pkg::*;
#(
	parameter int CH_NUM = CRAC_CH_NUM
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Select value
	input wire logic [$clog2(CH_NUM)-1:0] sel,
	// One switch per channel pin
	output logic [CH_NUM-1:0] sw_on
);
	// Elaboration check: only power-of-two widths decode cleanly
	localparam int SEL_W = $clog2(CH_NUM);
	if (CH_NUM < 2 || (CH_NUM & (CH_NUM - 1)) != 0)
	begin : g_bad_ch
		$error("CH_NUM must be a power of two");
	end

	// ----------------------------------------
	// Registered decode, so exactly one switch
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < CH_NUM; gi++)
		begin : g_sw
			always_ff @(posedge clk_sys)
			begin
				if (rst)
					sw_on[gi] <= (gi == 0);
				else
					sw_on[gi] <= (sel == SEL_W'(gi));
			end
		end
	endgenerate

	a_onehot_sw: assert property (@(posedge clk_sys) disable iff (rst) $onehot(sw_on))
		else $error("current switch not one-hot");
endmodule

/* File: src/crac_top.sv */
// Current route and conditioning amplifier register block, device side.
// Assumes host port strobes are synchronous to clk_sys, one cycle each.
//
// Contract
// - Current source connects to exactly one of 64 channel pins.
// - Low six bits give value 0..63; pin is value plus one; bits 7..6 unused.
// - Amplifier bit 6 set turns the filter amplifier off for external input.
// - Bits 5..4 pick second pole: 400 Hz, 2 kHz, 10 kHz.
// - Bits 3..2 pick first pole: 400 Hz, 2 kHz, 10 kHz.
// - Bits 1..0 pick gain: 0.4, 2.0, 10.
// - Gain code 11 should not be written; if written, gain is 10.
// - Low impedance drive only when shut-off and float bits both clear.
`timescale 1ns/1ps
module crac_top
	import crac_pkg::*;
#(
	parameter int CH_NUM = CRAC_CH_NUM
)
(
	// Clock and reset
	clk_sys,
	rst,
	// Host register port
	host_addr,
	host_wdata,
	host_wr,
	host_rd,
	host_rdata,
	// Converter control float bit from its register
	converter_input_float_bit,
	// Analog controls
	cur_sw_on,
	cur_pin_num,
	amp_ctl
);
	input wire logic clk_sys;
	input wire logic rst;
	input wire logic [CRAC_AW-1:0] host_addr;
	input wire logic [CRAC_DW-1:0] host_wdata;
	input wire logic host_wr;
	input wire logic host_rd;
	output logic [CRAC_DW-1:0] host_rdata;
	input wire logic converter_input_float_bit;
	output logic [CH_NUM-1:0] cur_sw_on;
	output logic [6:0] cur_pin_num;
	output crac_amp_ctl_t amp_ctl;

	// Elaboration check: the select field is six bits wide, so 64 ways only
	if (CH_NUM != CRAC_CH_NUM)
	begin : g_bad_ch
		$error("CH_NUM must match the 6-bit select field");
	end

	// Pole code to one-hot, reserved code kept at 400 Hz
	function automatic logic [2:0] pole_dec(input logic [1:0] c);
		case (crac_pole_t'(c))
			CRAC_POLE_400: pole_dec = 3'h1;
			CRAC_POLE_2K: pole_dec = 3'h2;
			CRAC_POLE_10K: pole_dec = 3'h4;
			default: pole_dec = 3'h1;
		endcase
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] cur_sel_r;
	logic [7:0] amp_cfg_r;
	logic [7:0] rdata_nxt;

	// Current channel select; unused bits masked on write
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			cur_sel_r <= CRAC_RST_CUR_SEL;
		else if (host_wr && host_addr == CRAC_OFS_CUR_SEL)
			cur_sel_r <= host_wdata & CRAC_MASK_CUR_SEL;
	end

	// Amplifier configuration
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			amp_cfg_r <= CRAC_RST_AMP_CFG;
		else if (host_wr && host_addr == CRAC_OFS_AMP_CFG)
			amp_cfg_r <= host_wdata & CRAC_MASK_AMP_CFG;
	end

	// Read mux; other addresses belong to other blocks and read zero here
	always_comb
	begin
		rdata_nxt = 8'h00;
		if (host_addr == CRAC_OFS_CUR_SEL)
			rdata_nxt = cur_sel_r;
		else if (host_addr == CRAC_OFS_AMP_CFG)
			rdata_nxt = amp_cfg_r;
	end

	// Read data registered so the output is a flop
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			host_rdata <= 8'h00;
		else if (host_rd)
			host_rdata <= rdata_nxt;
	end

	// ----------------------------------------
	// Current source routing
	// ----------------------------------------
	crac_decode #(.CH_NUM(CH_NUM)) u_dec
	(
		.clk_sys(clk_sys),
		.rst(rst),
		.sel(cur_sel_r[5:0]),
		.sw_on(cur_sw_on)
	);

	// Pin number, value plus one, for status and wiring checks
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			cur_pin_num <= 7'h01;
		else
			cur_pin_num <= {1'b0, cur_sel_r[5:0]} + 7'h01;
	end

	// ----------------------------------------
	// Amplifier controls
	// ----------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			amp_ctl.amp_on <= 1'b1;
			amp_ctl.drive_low_z <= 1'b0;
			amp_ctl.pole1_onehot <= 3'h1;
			amp_ctl.pole2_onehot <= 3'h1;
			amp_ctl.gain_onehot <= 3'h1;
		end
		else
		begin
			amp_ctl.amp_on <= ~amp_cfg_r[CRAC_BIT_SHUTOFF];
			// Float bit alone also releases the drive
			amp_ctl.drive_low_z <= ~amp_cfg_r[CRAC_BIT_SHUTOFF] & ~converter_input_float_bit;
			amp_ctl.pole2_onehot <= pole_dec(amp_cfg_r[CRAC_POS_POLE2 +: 2]);
			amp_ctl.pole1_onehot <= pole_dec(amp_cfg_r[CRAC_POS_POLE1 +: 2]);
			case (crac_gain_t'(amp_cfg_r[CRAC_POS_GAIN +: 2]))
				CRAC_GAIN_0P4: amp_ctl.gain_onehot <= 3'h1;
				CRAC_GAIN_2P0: amp_ctl.gain_onehot <= 3'h2;
				CRAC_GAIN_10: amp_ctl.gain_onehot <= 3'h4;
				default: amp_ctl.gain_onehot <= 3'h4;
			endcase
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Controls land two edges after a write: register first, then control flop
	a_route_follows: assert property (@(posedge clk_sys) disable iff (rst)
		host_wr && host_addr == CRAC_OFS_CUR_SEL ##2 1'b1 |-> cur_sw_on[$past(host_wdata[5:0], 2)])
		else $error("switch does not follow select write");
	a_pin_plus_one: assert property (@(posedge clk_sys) disable iff (rst)
		host_wr && host_addr == CRAC_OFS_CUR_SEL |-> ##2 cur_pin_num == {1'b0, $past(host_wdata[5:0], 2)} + 7'h01)
		else $error("pin number is not select plus one");
	a_shutoff_amp: assert property (@(posedge clk_sys) disable iff (rst)
		host_wr && host_addr == CRAC_OFS_AMP_CFG |-> ##2 amp_ctl.amp_on == ~$past(host_wdata[6], 2))
		else $error("shut-off bit not applied");
	a_pole2_map: assert property (@(posedge clk_sys) disable iff (rst)
		host_wr && host_addr == CRAC_OFS_AMP_CFG && host_wdata[5:4] == 2'h2 |-> ##2 amp_ctl.pole2_onehot == 3'h4)
		else $error("second pole map wrong");
	a_pole1_map: assert property (@(posedge clk_sys) disable iff (rst)
		host_wr && host_addr == CRAC_OFS_AMP_CFG && host_wdata[3:2] == 2'h1 |-> ##2 amp_ctl.pole1_onehot == 3'h2)
		else $error("first pole map wrong");
	a_gain_low: assert property (@(posedge clk_sys) disable iff (rst)
		host_wr && host_addr == CRAC_OFS_AMP_CFG && host_wdata[1:0] == 2'h0 |-> ##2 amp_ctl.gain_onehot == 3'h1)
		else $error("gain 0.4 not applied");
	a_gain_rsv_ten: assert property (@(posedge clk_sys) disable iff (rst)
		host_wr && host_addr == CRAC_OFS_AMP_CFG && host_wdata[1:0] == 2'h3 |-> ##2 amp_ctl.gain_onehot == 3'h4)
		else $error("gain code 11 not mapped to 10");
	a_low_z_cond: assert property (@(posedge clk_sys) disable iff (rst)
		amp_ctl.drive_low_z |-> !$past(amp_cfg_r[CRAC_BIT_SHUTOFF]) && !$past(converter_input_float_bit))
		else $error("low impedance drive while disabled");
	a_unused_zero: assert property (@(posedge clk_sys) disable iff (rst)
		host_rd && host_addr == CRAC_OFS_CUR_SEL |=> host_rdata[7:6] == 2'h0)
		else $error("unused bits read non-zero");
	a_unused_amp: assert property (@(posedge clk_sys) disable iff (rst)
		host_rd && host_addr == CRAC_OFS_AMP_CFG |=> host_rdata[7] == 1'b0)
		else $error("amplifier unused bit reads non-zero");
	a_gain_mid: assert property (@(posedge clk_sys) disable iff (rst)
		host_wr && host_addr == CRAC_OFS_AMP_CFG && host_wdata[1:0] == 2'h1 |-> ##2 amp_ctl.gain_onehot == 3'h2)
		else $error("gain 2.0 not applied");
	a_gain_high: assert property (@(posedge clk_sys) disable iff (rst)
		host_wr && host_addr == CRAC_OFS_AMP_CFG && host_wdata[1:0] == 2'h2 |-> ##2 amp_ctl.gain_onehot == 3'h4)
		else $error("gain 10 not applied");
	a_pole_rsv: assert property (@(posedge clk_sys) disable iff (rst)
		host_wr && host_addr == CRAC_OFS_AMP_CFG && host_wdata[5:4] == 2'h3 |-> ##2 amp_ctl.pole2_onehot == 3'h1)
		else $error("unused pole code not held at lowest pole");
	// Reverse side of the low impedance rule; first edge after reset is skipped
	a_low_z_on: assert property (@(posedge clk_sys) disable iff (rst)
		!$past(rst) && !$past(amp_cfg_r[CRAC_BIT_SHUTOFF]) && !$past(converter_input_float_bit)
		|-> amp_ctl.drive_low_z)
		else $error("low impedance drive missing while enabled");

	// Read side and write decode
	a_rdata_hold: assert property (@(posedge clk_sys) disable iff (rst)
		!host_rd |=> $stable(host_rdata))
		else $error("read data changed without a read");
	a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (rst)
		host_rd && host_addr != CRAC_OFS_CUR_SEL && host_addr != CRAC_OFS_AMP_CFG |=> host_rdata == 8'h00)
		else $error("unmapped address reads non-zero");
	a_sel_ignore: assert property (@(posedge clk_sys) disable iff (rst)
		!(host_wr && host_addr == CRAC_OFS_CUR_SEL) |=> $stable(cur_sel_r))
		else $error("select register changed without its write");
	a_amp_ignore: assert property (@(posedge clk_sys) disable iff (rst)
		!(host_wr && host_addr == CRAC_OFS_AMP_CFG) |=> $stable(amp_cfg_r))
		else $error("amplifier register changed without its write");

	c_write_sel: cover property (@(posedge clk_sys) host_wr && host_addr == CRAC_OFS_CUR_SEL && host_wdata[5:0] == 6'h3F);
	c_gain_rsv: cover property (@(posedge clk_sys) amp_ctl.gain_onehot == 3'h4 && amp_cfg_r[1:0] == 2'h3);
	c_shutoff: cover property (@(posedge clk_sys) !amp_ctl.amp_on);
	c_read_amp: cover property (@(posedge clk_sys) host_rd && host_addr == CRAC_OFS_AMP_CFG);
	c_float_only: cover property (@(posedge clk_sys) amp_ctl.amp_on && !amp_ctl.drive_low_z);
endmodule

/* File: dv/crac_host_model.sv */
// Host side model: drives the register port of the block.
// Assumes the block samples strobes at rising edges of clk_sys.
`timescale 1ns/1ps
module crac_host_model
	import crac_pkg::*;
(
	// Clock
	input wire logic clk_sys,
	// Register port
	output logic [CRAC_AW-1:0] host_addr,
	output logic [CRAC_DW-1:0] host_wdata,
	output logic host_wr,
	output logic host_rd,
	input wire logic [CRAC_DW-1:0] host_rdata
);
	// Idle port from time zero
	initial
	begin
		host_addr = '0;
		host_wdata = '0;
		host_wr = 1'b0;
		host_rd = 1'b0;
	end
	// One write; released data is inverted so a stale byte never looks valid
	task automatic wr_reg(input logic [CRAC_AW-1:0] a, input logic [CRAC_DW-1:0] d);
		@(posedge clk_sys);
		host_addr <= a;
		host_wdata <= d;
		host_wr <= 1'b1;
		@(posedge clk_sys);
		host_wr <= 1'b0;
		host_wdata <= ~d;
	endtask
	// One read; data is taken once the registered answer has landed
	task automatic rd_reg(input logic [CRAC_AW-1:0] a, output logic [CRAC_DW-1:0] d);
		@(posedge clk_sys);
		host_addr <= a;
		host_rd <= 1'b1;
		@(posedge clk_sys);
		host_rd <= 1'b0;
		@(posedge clk_sys);
		#1;
		d = host_rdata;
	endtask
endmodule

/* File: dv/tb.sv */
// Testbench for the current route and amplifier register block.
// Assumes the host model drives the register port and the bench the float bit.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
	$display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module tb;
	import crac_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic flt = 1'b0;
	logic [CRAC_AW-1:0] host_addr;
	logic [CRAC_DW-1:0] host_wdata;
	logic host_wr;
	logic host_rd;
	logic [CRAC_DW-1:0] host_rdata;
	logic [63:0] cur_sw_on;
	logic [6:0] cur_pin_num;
	crac_amp_ctl_t amp_ctl;
	logic [7:0] d;
	int error_cnt = 0;
	int cmp_count = 0;
	// ----------------------------------------
	// Clock, design and host
	// ----------------------------------------
	always #12.5 clk_sys = ~clk_sys;
	crac_top uut (.clk_sys(clk_sys), .rst(rst), .host_addr(host_addr), .host_wdata(host_wdata),
		.host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata), .converter_input_float_bit(flt),
		.cur_sw_on(cur_sw_on), .cur_pin_num(cur_pin_num), .amp_ctl(amp_ctl));
	crac_host_model host (.clk_sys(clk_sys), .host_addr(host_addr), .host_wdata(host_wdata),
		.host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata));
	// ----------------------------------------
	// Expectations
	// ----------------------------------------
	// Unused pole code falls back to the lowest pole
	function automatic logic [2:0] oh_pole(input logic [1:0] c);
		return (c == 2'h1) ? 3'h2 : ((c == 2'h2) ? 3'h4 : 3'h1);
	endfunction
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
		host.rd_reg(a, d);
		`CHK(d, e)
	endtask
	// Write both registers, let outputs settle three edges, check pins and readback
	task automatic apply(input logic [7:0] s, input logic [7:0] a, input logic f);
		@(posedge clk_sys);
		flt <= f;
		host.wr_reg(CRAC_OFS_CUR_SEL, s);
		host.wr_reg(CRAC_OFS_AMP_CFG, a);
		repeat (3) @(posedge clk_sys);
		#1;
		`CHK(cur_pin_num, {1'b0, s[5:0]} + 7'h01)
		`CHK(cur_sw_on, 64'h1 << s[5:0])
		`CHK(amp_ctl.amp_on, ~a[6])
		`CHK(amp_ctl.drive_low_z, ~a[6] & ~f)
		`CHK(amp_ctl.pole2_onehot, oh_pole(a[5:4]))
		`CHK(amp_ctl.pole1_onehot, oh_pole(a[3:2]))
		`CHK(amp_ctl.gain_onehot, a[1] ? 3'h4 : (a[0] ? 3'h2 : 3'h1))
		rd_chk(CRAC_OFS_CUR_SEL, s & 8'h3F);
		rd_chk(CRAC_OFS_AMP_CFG, a & 8'h7F);
	endtask
	// Watchdog against a hung sequence
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		stop_test();
	end
	// Main sequence
	initial
	begin
		void'($urandom(32'hB509AB13));
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		#1;
		`CHK(cur_pin_num, 7'h01)
		`CHK(cur_sw_on, 64'h1)
		`CHK(amp_ctl, {1'b1, ~flt, 3'h1, 3'h1, 3'h1})
		rd_chk(CRAC_OFS_CUR_SEL, 8'h00);
		rd_chk(CRAC_OFS_AMP_CFG, 8'h00);
		$display("Test reset done");
		apply(8'h1B, 8'h00, 1'b0);
		apply(8'hFF, 8'hFF, 1'b0);
		apply(8'h00, 8'h16, 1'b1);
		apply(8'h3F, 8'h29, 1'b0);
		apply(8'hC0, 8'h03, 1'b1);
		$display("Test corner codes done");
		for (int i = 0; i < 40; i++)
			apply(8'($urandom), 8'($urandom), 1'($urandom));
		$display("Test random writes done");
		apply(8'h2A, 8'h15, 1'b0);
		host.wr_reg(5'h05, 8'hA5);
		host.wr_reg(5'h1F, 8'h5A);
		rd_chk(CRAC_OFS_CUR_SEL, 8'h2A);
		rd_chk(CRAC_OFS_AMP_CFG, 8'h15);
		rd_chk(5'h05, 8'h00);
		$display("Test unmapped access done");
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		rd_chk(CRAC_OFS_CUR_SEL, 8'h00);
		rd_chk(CRAC_OFS_AMP_CFG, 8'h00);
		`CHK(cur_pin_num, 7'h01)
		`CHK(cur_sw_on, 64'h1)
		`CHK(amp_ctl, {1'b1, ~flt, 3'h1, 3'h1, 3'h1})
		$display("Test second reset done");
		stop_test();
	end
endmodule
